//--- src/ddr_read_burst_timing.sv
// Read-side burst engine of a DDR DRAM with an APB register file
//
// Contract
// - READ carries bank, start column and an auto-close flag.
// - Auto-close precharges the row after the burst; otherwise it stays open.
// - First data element appears read_delay = added_delay + column_delay.
// - Further beats follow on every rising and falling clock edge.
// - Strobe driven with data; low for read_lead_in before, else released.
// - After the last strobe transition, strobe low for half a clock; the code holds it low one clock, half a clock after data release.
// - Data lines released when the burst ends and nothing follows.
// - READs col_to_col_gap apart give seamless continuous data.
// - Chopped bursts col_to_col_gap apart leave an idle gap.
// - Repeated PRECHARGE allowed; close_time runs from the last one.
// - auto_close_bit high with READ engages read-with-auto-close.
// - Internal precharge starts added_delay+read_to_close_gap clocks after READ.
// - Internal precharge waits for open_min_time and minimum read_to_close_gap.
// - Postponed precharge starts close_time at its actual moment.
// - Internal precharge never earlier than four clocks after last prefetch.
// - Eight beats: field 00, or 01 with burst_select_bit high.
// - Four beats: field 10, or 01 with burst_select_bit low.
`timescale 1ns/10ps
module ddr_read_burst_timing
  import ddr_read_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic CK_I,
  input wire logic CS_N_I,
  input wire logic RAS_N_I,
  input wire logic CAS_N_I,
  input wire logic WE_N_I,
  input wire logic [2:0] BA_I,
  input wire logic [13:0] ADDR_I,
  output logic [7:0] DQ_O,
  output logic DQ_OE_O,
  output logic DQS_O,
  output logic DQS_N_O,
  output logic DQS_OE_O
);
  typedef enum logic [1:0] {OUT_IDLE, OUT_PRE, OUT_DATA, OUT_POST} out_state_t;

  function automatic logic [7:0] one_hot(input logic [2:0] b);
    one_hot = 8'h01 << b;
  endfunction : one_hot

  // Sequential burst order wrapping within the burst's aligned group
  function automatic logic [3:0] beat_index(input logic [3:0] col,
                                            input logic [2:0] beat,
                                            input logic chop);
    logic [2:0] low;
    low = col[2:0] + beat;
    beat_index = chop ? {col[3:2], low[1:0]} : {col[3], low};
  endfunction : beat_index

  logic [SYNC_WIDTH-1:0] pins;
  logic ck_s, ck_d, cs_n, ras_n, cas_n, we_n;
  logic [2:0] ba;
  logic [13:0] addr;
  logic ck_rise, ck_fall;

  pin_sync u_sync (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .d_i({CK_I, CS_N_I, RAS_N_I, CAS_N_I, WE_N_I, BA_I, ADDR_I}),
    .q_o(pins)
  );
  assign {ck_s, cs_n, ras_n, cas_n, we_n, ba, addr} = pins;
  assign ck_rise = ck_s & ~ck_d;
  assign ck_fall = ~ck_s & ck_d;

  // Commands are taken at each CK rise
  logic cmd_ok, cmd_rd, cmd_act, cmd_pre, rd_chop;
  logic [7:0] bank_sel, act_v, pre_v, rd_ap_v;
  assign cmd_ok = ck_rise & ~cs_n;
  assign cmd_rd = cmd_ok & ras_n & ~cas_n & we_n;
  assign cmd_act = cmd_ok & ~ras_n & cas_n & we_n;
  assign cmd_pre = cmd_ok & ~ras_n & cas_n & ~we_n;
  assign bank_sel = one_hot(ba);
  assign act_v = cmd_act ? bank_sel : 8'h00;
  // A10 on PRECHARGE closes every bank
  assign pre_v = cmd_pre ? (addr[10] ? 8'hff : bank_sel) : 8'h00;
  assign rd_ap_v = (cmd_rd && addr[10]) ? bank_sel : 8'h00;

  // Registers
  logic [1:0] bl_field, next_bl_field;
  logic [3:0] al, next_al, cl, next_cl;
  logic [31:0] timing, next_timing;
  logic [7:0] data_mem [16];
  logic [7:0] next_data_mem [16];
  logic [15:0] close_count, next_close_count;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [7:0] bank_open, bank_closing, ap_fire;
  logic out_busy;

  always_comb
  begin
    case (bl_field)
      BL_FIXED_CHOP: rd_chop = 1'b1;
      BL_ON_THE_FLY: rd_chop = ~addr[12];
      default: rd_chop = 1'b0;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_bank
      bank_close u_bank (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .ck_rise_i(ck_rise),
        .act_i(act_v[g]),
        .rd_ap_i(rd_ap_v[g]),
        .pre_i(pre_v[g]),
        .al_i(al),
        .rtp_ck_i(timing[RTP_CK_LSB+:4]),
        .rtp_sys_i(timing[RTP_SYS_LSB+:8]),
        .ras_sys_i(timing[RAS_SYS_LSB+:8]),
        .rp_sys_i(timing[RP_SYS_LSB+:8]),
        .open_o(bank_open[g]),
        .closing_o(bank_closing[g]),
        .ap_fire_o(ap_fire[g])
      );
    end
  endgenerate

  // APB slave: answer registered in setup, pready in the first access cycle
  logic setup, wr_en;
  assign setup = PSEL_I & ~PENABLE_I & ~PREADY_O;
  assign wr_en = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & ~PSLVERR_O;

  always_comb
  begin
    next_bl_field = bl_field;
    next_al = al;
    next_cl = cl;
    next_timing = timing;
    next_data_mem = data_mem;
    next_close_count = close_count + {15'h0000, |ap_fire};
    next_pready = setup;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (setup)
    begin
      case (PADDR_I)
        MODE_OFS:
          next_prdata = {20'h00000, cl, al, 2'h0, bl_field};
        TIMING_OFS:
          next_prdata = timing;
        STATUS_OFS:
          next_prdata = {15'h0000, out_busy, bank_closing, bank_open};
        CLOSE_COUNT_OFS:
          next_prdata = {16'h0000, close_count};
        default:
        begin
          if (PADDR_I >= DATA0_OFS && PADDR_I <= DATA3_OFS
              && PADDR_I[1:0] == 2'h0)
            next_prdata = {data_mem[{PADDR_I[3:2], 2'h3}],
                           data_mem[{PADDR_I[3:2], 2'h2}],
                           data_mem[{PADDR_I[3:2], 2'h1}],
                           data_mem[{PADDR_I[3:2], 2'h0}]};
          else
            next_pslverr = 1'b1;
        end
      endcase
      // Status and count are read-only, so writes to them are refused
      if (PWRITE_I && (PADDR_I == STATUS_OFS || PADDR_I == CLOSE_COUNT_OFS))
        next_pslverr = 1'b1;
    end
    else if (PREADY_O)
      next_pslverr = 1'b0;
    if (wr_en)
    begin
      if (PADDR_I == MODE_OFS)
      begin
        // New latencies apply to READs taken after the write
        next_bl_field = PWDATA_I[BL_LSB+:2];
        next_al = PWDATA_I[AL_LSB+:4];
        next_cl = PWDATA_I[CL_LSB+:4];
      end
      else if (PADDR_I == TIMING_OFS)
        next_timing = PWDATA_I;
      else
        for (int i = 0; i < 4; i++)
          next_data_mem[{PADDR_I[3:2], 2'(i)}] = PWDATA_I[8*i+:8];
    end
  end

  // Read-delay ring: a READ marks the slot read_delay CK rises ahead
  logic [4:0] ck_count, next_ck_count, now_idx, ahead_idx, rd_idx;
  logic slot_valid [SLOTS];
  logic next_slot_valid [SLOTS];
  logic [3:0] slot_col [SLOTS];
  logic [3:0] next_slot_col [SLOTS];
  logic slot_chop [SLOTS];
  logic next_slot_chop [SLOTS];
  out_state_t state, next_state;
  logic [2:0] beat, next_beat, last_beat;
  logic [3:0] cur_col, next_cur_col;
  logic cur_chop, next_cur_chop;
  logic [7:0] next_dq;
  logic next_dq_oe, next_dqs, next_dqs_oe;

  assign now_idx = ck_count + 5'h01;
  assign ahead_idx = now_idx + 5'h01;
  assign rd_idx = now_idx + {1'b0, al} + {1'b0, cl};
  assign last_beat = cur_chop ? LAST_BEAT_CHOP : LAST_BEAT_EIGHT;
  assign out_busy = (state != OUT_IDLE);

  always_comb
  begin
    next_ck_count = ck_rise ? now_idx : ck_count;
    next_slot_valid = slot_valid;
    next_slot_col = slot_col;
    next_slot_chop = slot_chop;
    next_state = state;
    next_beat = beat;
    next_cur_col = cur_col;
    next_cur_chop = cur_chop;
    next_dq = DQ_O;
    next_dq_oe = DQ_OE_O;
    next_dqs = DQS_O;
    next_dqs_oe = DQS_OE_O;
    if (ck_rise)
    begin
      next_slot_valid[now_idx] = 1'b0;
      if (slot_valid[now_idx])
      begin
        // Starts straight after a previous last beat, so data is seamless
        next_state = OUT_DATA;
        next_beat = 3'h0;
        next_cur_col = slot_col[now_idx];
        next_cur_chop = slot_chop[now_idx];
        next_dq = data_mem[beat_index(slot_col[now_idx], 3'h0,
                                      slot_chop[now_idx])];
        next_dq_oe = 1'b1;
        next_dqs = 1'b1;
        next_dqs_oe = 1'b1;
      end
      else if (state == OUT_DATA && beat != last_beat)
      begin
        next_beat = beat + 3'h1;
        next_dq = data_mem[beat_index(cur_col, beat + 3'h1, cur_chop)];
        next_dqs = 1'b1;
      end
      else if (slot_valid[ahead_idx])
      begin
        // A burst is due at the next CK rise: release data and drive the strobe low as its preamble
        next_state = OUT_PRE;
        next_dq_oe = 1'b0;
        next_dqs = 1'b0;
        next_dqs_oe = 1'b1;
      end
      else if (state == OUT_DATA)
      begin
        next_state = OUT_POST;
        next_dq_oe = 1'b0;
        next_dqs = 1'b0;
      end
      if (cmd_rd)
      begin
        next_slot_valid[rd_idx] = 1'b1;
        next_slot_col[rd_idx] = addr[3:0];
        next_slot_chop[rd_idx] = rd_chop;
      end
    end
    else if (ck_fall)
    begin
      if (state == OUT_DATA && beat != last_beat)
      begin
        next_beat = beat + 3'h1;
        next_dq = data_mem[beat_index(cur_col, beat + 3'h1, cur_chop)];
        next_dqs = 1'b0;
      end
      else if (state == OUT_POST)
      begin
        next_state = OUT_IDLE;
        next_dqs_oe = 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ck_d <= 1'b0;
      bl_field <= BL_RESET;
      al <= AL_RESET;
      cl <= CL_RESET;
      timing <= {RP_SYS_RESET, RAS_SYS_RESET, RTP_SYS_RESET, 4'h0,
                 RTP_CK_RESET};
      data_mem <= '{default: 8'h00};
      close_count <= 16'h0000;
      PRDATA_O <= 32'h0000_0000;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      ck_count <= 5'h00;
      slot_valid <= '{default: 1'b0};
      slot_col <= '{default: 4'h0};
      slot_chop <= '{default: 1'b0};
      state <= OUT_IDLE;
      beat <= 3'h0;
      cur_col <= 4'h0;
      cur_chop <= 1'b0;
      DQ_O <= 8'h00;
      DQ_OE_O <= 1'b0;
      DQS_O <= 1'b0;
      DQS_N_O <= 1'b1;
      DQS_OE_O <= 1'b0;
    end
    else if (CE_I)
    begin
      ck_d <= ck_s;
      bl_field <= next_bl_field;
      al <= next_al;
      cl <= next_cl;
      timing <= next_timing;
      data_mem <= next_data_mem;
      close_count <= next_close_count;
      PRDATA_O <= next_prdata;
      PREADY_O <= next_pready;
      PSLVERR_O <= next_pslverr;
      ck_count <= next_ck_count;
      slot_valid <= next_slot_valid;
      slot_col <= next_slot_col;
      slot_chop <= next_slot_chop;
      state <= next_state;
      beat <= next_beat;
      cur_col <= next_cur_col;
      cur_chop <= next_cur_chop;
      DQ_O <= next_dq;
      DQ_OE_O <= next_dq_oe;
      DQS_O <= next_dqs;
      DQS_N_O <= ~next_dqs;
      DQS_OE_O <= next_dqs_oe;
    end
  end
endmodule : ddr_read_burst_timing

//--- src/ddr_read_pkg.sv
// Constants shared by the DRAM read-side model
package ddr_read_pkg;
  // Register byte offsets
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] TIMING_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] CLOSE_COUNT_OFS = 8'h0c;
  localparam logic [7:0] DATA0_OFS = 8'h10;
  localparam logic [7:0] DATA3_OFS = 8'h1c;
  // Mode register fields
  localparam int BL_LSB = 0;
  localparam int AL_LSB = 4;
  localparam int CL_LSB = 8;
  // Timing register fields
  localparam int RTP_CK_LSB = 0;
  localparam int RTP_SYS_LSB = 8;
  localparam int RAS_SYS_LSB = 16;
  localparam int RP_SYS_LSB = 24;
  // Status register fields
  localparam int OPEN_LSB = 0;
  localparam int CLOSING_LSB = 8;
  localparam int BUSY_BIT = 16;
  // Values after reset
  localparam logic [1:0] BL_RESET = 2'h0;
  localparam logic [3:0] AL_RESET = 4'h0;
  localparam logic [3:0] CL_RESET = 4'h5;
  localparam logic [3:0] RTP_CK_RESET = 4'h4;
  localparam logic [7:0] RTP_SYS_RESET = 8'h08;
  localparam logic [7:0] RAS_SYS_RESET = 8'h08;
  localparam logic [7:0] RP_SYS_RESET = 8'h08;
  // Burst-length field codes
  localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BL_ON_THE_FLY = 2'h1;
  localparam logic [1:0] BL_FIXED_CHOP = 2'h2;
  // Clocks from the last prefetch before an internal precharge
  localparam logic [4:0] PREFETCH_TO_CLOSE_CK = 5'h04;
  // Last beat index of each burst size
  localparam logic [2:0] LAST_BEAT_EIGHT = 3'h7;
  localparam logic [2:0] LAST_BEAT_CHOP = 3'h3;
  // Read-delay slot ring depth, must exceed the largest read_delay
  localparam int SLOTS = 32;
  localparam int SYNC_WIDTH = 22;
endpackage : ddr_read_pkg

//--- src/pin_sync.sv
// Two-stage synchroniser for the link pins
`timescale 1ns/10ps
module pin_sync
  import ddr_read_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [SYNC_WIDTH-1:0] d_i,
  output logic [SYNC_WIDTH-1:0] q_o
);
  logic [SYNC_WIDTH-1:0] meta;
  logic [SYNC_WIDTH-1:0] next_meta;
  logic [SYNC_WIDTH-1:0] next_q;

  always_comb
  begin
    next_meta = ce_i ? d_i : meta;
    next_q = ce_i ? meta : q_o;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= '0;
      q_o <= '0;
    end
    else
    begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end
endmodule : pin_sync

//--- src/bank_close.sv
// Per-bank row state and precharge timing
`timescale 1ns/10ps
module bank_close
  import ddr_read_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic ck_rise_i,
  input wire logic act_i,
  input wire logic rd_ap_i,
  input wire logic pre_i,
  input wire logic [3:0] al_i,
  input wire logic [3:0] rtp_ck_i,
  input wire logic [7:0] rtp_sys_i,
  input wire logic [7:0] ras_sys_i,
  input wire logic [7:0] rp_sys_i,
  output logic open_o,
  output logic closing_o,
  output logic ap_fire_o
);
  logic [7:0] ras_left, next_ras_left;
  logic [7:0] rtp_left, next_rtp_left;
  logic [7:0] rp_left, next_rp_left;
  logic [4:0] ck_wait, next_ck_wait;
  logic [3:0] al_wait, next_al_wait;
  logic ap_pend, next_ap_pend;
  logic rtp_arm, next_rtp_arm;
  logic next_open, next_ap_fire;
  logic [4:0] nominal;
  logic [4:0] floor_ck;

  assign closing_o = (rp_left != 8'h00);

  always_comb
  begin
    nominal = {1'b0, al_i} + {1'b0, rtp_ck_i};
    floor_ck = {1'b0, al_i} + PREFETCH_TO_CLOSE_CK;
    next_ras_left = ras_left;
    next_rtp_left = rtp_left;
    next_rp_left = rp_left;
    next_ck_wait = ck_wait;
    next_al_wait = al_wait;
    next_ap_pend = ap_pend;
    next_rtp_arm = rtp_arm;
    next_open = open_o;
    next_ap_fire = 1'b0;
    if (ras_left != 8'h00)
      next_ras_left = ras_left - 8'h01;
    if (rp_left != 8'h00)
      next_rp_left = rp_left - 8'h01;
    if (rtp_arm && rtp_left != 8'h00)
      next_rtp_left = rtp_left - 8'h01;
    if (ap_pend && ck_rise_i)
    begin
      if (ck_wait != 5'h00)
        next_ck_wait = ck_wait - 5'h01;
      // Analog read_to_close_gap is counted from added_delay after READ
      if (al_wait != 4'h0)
      begin
        next_al_wait = al_wait - 4'h1;
        if (al_wait == 4'h1)
          next_rtp_arm = 1'b1;
      end
    end
    // Fires in the cycle the last wait ends, not at a later CK edge
    if (ap_pend && ck_wait == 5'h00 && rtp_arm && rtp_left == 8'h00
        && ras_left == 8'h00)
    begin
      next_ap_pend = 1'b0;
      next_open = 1'b0;
      next_rp_left = rp_sys_i;
      next_ap_fire = 1'b1;
    end
    if (rd_ap_i)
    begin
      next_ap_pend = 1'b1;
      next_ck_wait = (nominal > floor_ck) ? nominal : floor_ck;
      next_al_wait = al_i;
      next_rtp_arm = (al_i == 4'h0);
      next_rtp_left = rtp_sys_i;
    end
    if (pre_i)
    begin
      next_open = 1'b0;
      next_ap_pend = 1'b0;
      next_rp_left = rp_sys_i;
    end
    if (act_i)
    begin
      next_open = 1'b1;
      next_ras_left = ras_sys_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ras_left <= 8'h00;
      rtp_left <= 8'h00;
      rp_left <= 8'h00;
      ck_wait <= 5'h00;
      al_wait <= 4'h0;
      ap_pend <= 1'b0;
      rtp_arm <= 1'b0;
      open_o <= 1'b0;
      ap_fire_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ras_left <= next_ras_left;
      rtp_left <= next_rtp_left;
      rp_left <= next_rp_left;
      ck_wait <= next_ck_wait;
      al_wait <= next_al_wait;
      ap_pend <= next_ap_pend;
      rtp_arm <= next_rtp_arm;
      open_o <= next_open;
      ap_fire_o <= next_ap_fire;
    end
  end
endmodule : bank_close

//--- test/ddr_read_burst_chk.sv
// Port-level assertions for the read burst engine
`timescale 1ns/10ps
module ddr_read_burst_chk
  import ddr_read_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic DQ_OE_O,
  input wire logic DQS_O,
  input wire logic DQS_N_O,
  input wire logic DQS_OE_O
);
  default clocking @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  sequence setup_s;
    PSEL_I && !PENABLE_I && CE_I;
  endsequence
  // Preamble is one link clock, eight system clocks
  sequence lead_s;
    (DQS_OE_O && !DQS_O && !DQ_OE_O) [*6] ##[1:3] (DQ_OE_O && DQS_O);
  endsequence
  sequence tail_s;
    (DQS_OE_O && !DQS_O && !DQ_OE_O) [*3];
  endsequence
  a_lead_in: assert property ($rose(DQS_OE_O) |-> lead_s)
    else $error("preamble wrong");
  a_first_beat: assert property ($rose(DQ_OE_O) |-> DQS_O &&
    $past(DQS_OE_O) && !$past(DQS_O)) else $error("first beat wrong");
  a_tail_low: assert property ($fell(DQ_OE_O) |-> tail_s)
    else $error("postamble wrong");
  a_strobe_release: assert property ($fell(DQS_OE_O) |-> !DQ_OE_O &&
    !$past(DQS_O)) else $error("strobe released badly");
  a_strobe_pair: assert property (DQS_N_O == !DQS_O)
    else $error("strobe pair not complementary");
  a_data_strobed: assert property (DQ_OE_O |-> DQS_OE_O)
    else $error("data without strobe");
  a_beat_hold: assert property (DQ_OE_O && $changed(DQS_O) |=>
    $stable(DQS_O) [*2]) else $error("beat too short");
  a_apb_answer: assert property (setup_s |=> PREADY_O)
    else $error("no ready after setup");
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready too long");
  a_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
    else $error("read data outside answer");
  a_refuse_map: assert property (setup_s ##0 (PADDR_I > DATA3_OFS) |=>
    PSLVERR_O && PRDATA_O == 32'h0) else $error("unmapped accepted");
endmodule : ddr_read_burst_chk

bind ddr_read_burst_timing ddr_read_burst_chk chk (
  .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .DQ_OE_O(DQ_OE_O), .DQS_O(DQS_O), .DQS_N_O(DQS_N_O),
  .DQS_OE_O(DQS_OE_O));

//--- test/ddr_ctl_model.sv
// Memory controller model: link clock, commands, strobed capture
`timescale 1ns/10ps
module ddr_ctl_model
(
  input wire logic sys_clk_i,
  output logic ck_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [2:0] ba_o,
  output logic [13:0] addr_o,
  input wire logic [7:0] dq_i,
  input wire logic dq_oe_i,
  input wire logic dqs_i,
  input wire logic dqs_oe_i
);
  int rise_cnt = 0;
  logic [7:0] got_q[$];
  int got_ck[$];
  logic last_dqs = 1'b0;
  initial
  begin
    {ck_o, cs_n_o, ras_n_o, cas_n_o, we_n_o} = 5'h0f;
    ba_o = 3'h0;
    addr_o = 14'h0;
    // Odd start keeps link edges off the system edges
    #37;
    forever #80 ck_o = ~ck_o;
  end
  always @(posedge ck_o) rise_cnt <= rise_cnt + 1;
  // Every strobe change while driving carries one beat
  always @(posedge sys_clk_i)
  begin
    if (dq_oe_i === 1'b1 && dqs_oe_i === 1'b1 && dqs_i !== last_dqs)
    begin
      got_q.push_back(dq_i);
      got_ck.push_back(rise_cnt);
    end
    last_dqs <= dqs_i;
  end
  task automatic cmd(input logic [2:0] rcw, input logic [2:0] ba,
                     input logic [13:0] a, output int r);
    @(negedge ck_o);
    @(posedge sys_clk_i);
    cs_n_o <= 1'b0;
    {ras_n_o, cas_n_o, we_n_o} <= rcw;
    ba_o <= ba;
    addr_o <= a;
    @(posedge ck_o);
    #1 r = rise_cnt;
    @(negedge ck_o);
    @(posedge sys_clk_i);
    cs_n_o <= 1'b1;
  endtask : cmd
  task automatic idle(input int n);
    repeat (n) @(posedge ck_o);
  endtask : idle
endmodule : ddr_ctl_model

//--- test/testbench.sv
// Self-checking bench for the read burst engine
`timescale 1ns/10ps
module testbench;
  import ddr_read_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel, penable, pwrite;
  logic [7:0] paddr, dq;
  logic [31:0] pwdata, prdata, q, d;
  logic pready, pslverr, e, ck, cs_n, ras_n, cas_n, we_n;
  logic dq_oe, dqs, dqs_n, dqs_oe;
  logic [2:0] ba;
  logic [13:0] addr;
  logic [7:0] mem [16];
  logic [7:0] exp_q[$];
  int exp_ck[$];
  int fails = 0, total_checks = 0, seed = 92, cyc = 0, r, al, cl;
  logic [3:0] col;
  logic [7:0] bad [4] = '{8'h20, 8'h02, STATUS_OFS, CLOSE_COUNT_OFS};
  logic [1:0] fld [6] = '{BL_FIXED_EIGHT, BL_ON_THE_FLY, BL_ON_THE_FLY,
                          BL_FIXED_CHOP, BL_FIXED_EIGHT, BL_FIXED_CHOP};
  logic a12 [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  int lens [6] = '{8, 8, 4, 4, 8, 4};
  always #10 clk = ~clk;
  ddr_read_burst_timing dut (.SYS_CLK_I(clk), .RST_N_I(rst_n),
    .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .CK_I(ck), .CS_N_I(cs_n),
    .RAS_N_I(ras_n), .CAS_N_I(cas_n), .WE_N_I(we_n), .BA_I(ba),
    .ADDR_I(addr), .DQ_O(dq), .DQ_OE_O(dq_oe), .DQS_O(dqs),
    .DQS_N_O(dqs_n), .DQS_OE_O(dqs_oe));
  ddr_ctl_model ctl (.sys_clk_i(clk), .ck_o(ck), .cs_n_o(cs_n),
    .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba),
    .addr_o(addr), .dq_i(dq), .dq_oe_i(dq_oe), .dqs_i(dqs),
    .dqs_oe_i(dqs_oe));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
    @(posedge clk);
    penable <= 1'b1;
    // Ends on pready; if it never comes, only the bench timeout ends this wait
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Reference beats: wrap inside the eight- or four-beat group
  task burst(input int rd, input logic [3:0] c, input int n, input int rl);
    logic [3:0] idx;
    for (int b = 0; b < n; b++)
    begin
      idx = (n == 8) ? {c[3], 3'(c[2:0] + b)} : {c[3:2], 2'(c[1:0] + b)};
      exp_q.push_back(mem[idx]);
      exp_ck.push_back(rd + rl + b / 2);
    end
  endtask : burst
  task compare_all;
    check(ctl.got_q.size(), exp_q.size());
    while (exp_q.size() > 0 && ctl.got_q.size() > 0)
    begin
      check(ctl.got_q.pop_front(), exp_q.pop_front());
      check(ctl.got_ck.pop_front(), exp_ck.pop_front());
    end
    exp_q.delete();
    exp_ck.delete();
    ctl.got_q.delete();
    ctl.got_ck.delete();
  endtask : compare_all
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, MODE_OFS, 32'h0);
    check(q, {CL_RESET, AL_RESET, 2'h0, BL_RESET});
    apb(1'b0, TIMING_OFS, 32'h0);
    check(q, {RP_SYS_RESET, RAS_SYS_RESET, RTP_SYS_RESET, 4'h0,
      RTP_CK_RESET});
    for (int i = 0; i < 4; i++)
    begin
      apb(i > 1, bad[i], 32'hffffffff);
      check({31'h0, e}, 32'h1);
      check(q, 32'h0);
    end
    for (int w = 0; w < 4; w++)
    begin
      d = $random(seed);
      apb(1'b1, DATA0_OFS + 8'(4 * w), d);
      for (int k = 0; k < 4; k++) mem[4 * w + k] = d[8 * k +: 8];
    end
    $display("test registers done");
    ctl.cmd(3'b011, 3'h1, 14'h0, r);
    for (int m = 0; m < 6; m++)
    begin
      al = (m > 3) ? 0 : {$random(seed)} % 3;
      cl = (m > 3) ? 5 : 5 + {$random(seed)} % 3;
      apb(1'b1, MODE_OFS, {20'h0, 4'(cl), 4'(al), 2'h0, fld[m]});
      col = $random(seed);
      ctl.cmd(3'b101, 3'h1, {1'b0, a12[m], 8'h0, col}, r);
      burst(r, col, lens[m], al + cl);
      if (m > 3)
      begin
        ctl.idle(3);
        ctl.cmd(3'b101, 3'h1, {1'b0, a12[m], 8'h0, ~col}, r);
        burst(r, ~col, lens[m], al + cl);
      end
      ctl.idle(al + cl + 10);
      compare_all();
      $display("test burst mode %0d done", m);
    end
    apb(1'b0, STATUS_OFS, 32'h0);
    check({q[OPEN_LSB + 1], q[BUSY_BIT]}, 2'b10);
    apb(1'b0, CLOSE_COUNT_OFS, 32'h0);
    check(q, 32'h0);
    ctl.cmd(3'b101, 3'h1, {4'b0101, 6'h0, col}, r);
    burst(r, col, lens[5], 5);
    ctl.idle(20);
    compare_all();
    apb(1'b0, STATUS_OFS, 32'h0);
    check(q[OPEN_LSB + 1], 1'b0);
    apb(1'b0, CLOSE_COUNT_OFS, 32'h0);
    check(q, 32'h1);
    $display("test auto close done");
    ctl.idle((RTP_SYS_RESET + RP_SYS_RESET + 7) / 8);
    ctl.cmd(3'b011, 3'h1, 14'h0, r);
    col = $random(seed);
    ctl.cmd(3'b101, 3'h1, {4'b0000, 6'h0, col}, r);
    burst(r, col, lens[5], 5);
    ctl.idle(6);
    // A WRITE is ignored by the read engine and must add no beats
    ctl.cmd(3'b100, 3'h1, 14'h0, r);
    ctl.cmd(3'b010, 3'h1, 14'h0, r);
    ctl.cmd(3'b010, 3'h1, 14'h0, r);
    apb(1'b0, STATUS_OFS, 32'h0);
    check({q[CLOSING_LSB + 1], q[OPEN_LSB + 1]}, 2'b10);
    ctl.idle(10);
    compare_all();
    apb(1'b0, CLOSE_COUNT_OFS, 32'h0);
    check(q, 32'h1);
    $display("test precharge done");
    tally_and_finish();
  end
endmodule : testbench
